// [verilog/bit_invert_cfg.svh]
// constants for the bit-invert instruction executor
`ifndef BIT_INVERT_CFG_SVH
`define BIT_INVERT_CFG_SVH
`define OPCODE_HI 4'h7
`define ACCESS_SPLIT 8'h60
`define INDEXED_LIMIT 8'h5F
`define ACCESS_SFR_BANK 4'hF
`define SKIP_NOP_CYCLES 2'h2
`define OPCODE_MSB 15
`define OPCODE_LSB 12
`define BIT_SEL_MSB 11
`define BIT_SEL_LSB 9
`define BANK_SEL_BIT 8
`define REG_F_MSB 7
`define REG_F_LSB 0
`define MIN_ADDR_W 12
`endif

// [verilog/bit_invert_pkg.sv]
// types for the bit-invert instruction executor
package bit_invert_pkg;
   typedef enum logic [1:0] {
      PH_Q1,
      PH_Q2,
      PH_Q3,
      PH_Q4
   } phase_t;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_SKIP
   } exec_state_t;
endpackage

// [verilog/bit_invert_instruction.sv]
// bit-invert instruction decode and execute core slice
`timescale 1ns/1ps
`include "bit_invert_cfg.svh"

module bit_invert_instruction #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // instruction fetch
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic skip_two_word,
   input wire logic extended_set_en,
   // core registers
   input wire logic [3:0] bank_selection_register,
   input wire logic [ADDR_W-1:0] index_base,
   // data memory port
   output logic [ADDR_W-1:0] mem_addr,
   output logic mem_rd,
   input wire logic [7:0] mem_rdata,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   // status
   output logic instr_ready,
   output logic instr_done,
   output logic status_write_en
);

   // --------------------------------------------------
   // elaboration checks
   // --------------------------------------------------
   // bank concatenations and the access split need at least twelve address bits
   if (ADDR_W < `MIN_ADDR_W) begin : gen_addr_w_check
      $error("ADDR_W must be at least 12");
   end

   // --------------------------------------------------
   // declarations
   // --------------------------------------------------
   // sequencer state
   bit_invert_pkg::exec_state_t state_q;
   bit_invert_pkg::exec_state_t state_d;
   bit_invert_pkg::phase_t phase_q;
   bit_invert_pkg::phase_t phase_d;
   logic [1:0] skip_cnt_q;
   logic [1:0] skip_cnt_d;
   // datapath state
   logic [2:0] bit_sel_q;
   logic [2:0] bit_sel_d;
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] addr_d;
   logic [7:0] data_q;
   logic [7:0] data_d;
   // decode results
   logic [3:0] opcode;
   logic [2:0] bit_field;
   logic bank_a;
   logic [7:0] reg_f;
   logic is_invert;
   logic use_indexed;
   logic in_access_low;
   logic start_exec;
   logic start_skip;
   logic [7:0] toggle_mask;
   logic [ADDR_W-1:0] eff_addr;

   // --------------------------------------------------
   // decode and address resolution
   // --------------------------------------------------
   // split the instruction word into its fields
   assign opcode = instr_word[`OPCODE_MSB:`OPCODE_LSB];
   assign bit_field = instr_word[`BIT_SEL_MSB:`BIT_SEL_LSB];
   assign bank_a = instr_word[`BANK_SEL_BIT];
   assign reg_f = instr_word[`REG_F_MSB:`REG_F_LSB];

   assign is_invert = (opcode == `OPCODE_HI);

   // indexed mode needs the extended set and a clear bank choice
   assign use_indexed = !bank_a && extended_set_en && (reg_f <= `INDEXED_LIMIT);
   // lower part of the access bank maps onto bank zero unless indexed mode takes the offset
   assign in_access_low = (reg_f < `ACCESS_SPLIT);

   // effective data address from bank choice
   always_comb begin
      eff_addr = '0;
      if (use_indexed) begin
         eff_addr = index_base + ADDR_W'(reg_f);
      end else if (!bank_a) begin
         if (in_access_low) begin
            eff_addr = ADDR_W'(reg_f);
         end else begin
            eff_addr = ADDR_W'({`ACCESS_SFR_BANK, reg_f});
         end
      end else begin
         eff_addr = ADDR_W'({bank_selection_register, reg_f});
      end
   end

   // --------------------------------------------------
   // start conditions
   // --------------------------------------------------
   // skip wins over a new word
   assign start_skip = skip_two_word;
   // only a matching word starts execution
   assign start_exec = instr_valid && is_invert;

   // one-hot mask for the chosen bit
   assign toggle_mask = 8'h01 << bit_sel_q;

   // --------------------------------------------------
   // phase sequencer
   // --------------------------------------------------
   // next state, phase and datapath values
   always_comb begin
      state_d = state_q;
      phase_d = phase_q;
      skip_cnt_d = skip_cnt_q;
      bit_sel_d = bit_sel_q;
      addr_d = addr_q;
      data_d = data_q;
      case (state_q)
         bit_invert_pkg::ST_IDLE: begin
            phase_d = bit_invert_pkg::PH_Q1;
            if (start_skip) begin
               state_d = bit_invert_pkg::ST_SKIP;
               skip_cnt_d = `SKIP_NOP_CYCLES;
            end else if (start_exec) begin
               state_d = bit_invert_pkg::ST_EXEC;
               bit_sel_d = bit_field;
               addr_d = eff_addr;
            end
         end
         bit_invert_pkg::ST_EXEC: begin
            case (phase_q)
               // q1 decode, nothing to move yet
               bit_invert_pkg::PH_Q1: begin
                  phase_d = bit_invert_pkg::PH_Q2;
               end
               // q2 read the addressed byte
               bit_invert_pkg::PH_Q2: begin
                  phase_d = bit_invert_pkg::PH_Q3;
                  data_d = mem_rdata;
               end
               // q3 process the data
               bit_invert_pkg::PH_Q3: begin
                  phase_d = bit_invert_pkg::PH_Q4;
                  data_d = data_q ^ toggle_mask;
               end
               // q4 write back, then idle
               bit_invert_pkg::PH_Q4: begin
                  phase_d = bit_invert_pkg::PH_Q1;
                  state_d = bit_invert_pkg::ST_IDLE;
               end
               default: begin
                  phase_d = bit_invert_pkg::PH_Q1;
                  state_d = bit_invert_pkg::ST_IDLE;
               end
            endcase
         end
         bit_invert_pkg::ST_SKIP: begin
            // nop phases keep counting through the whole cycle
            phase_d = bit_invert_pkg::phase_t'(phase_q + 2'h1);
            if (phase_q == bit_invert_pkg::PH_Q4) begin
               skip_cnt_d = skip_cnt_q - 2'h1;
               // last nop cycle ends here
               if (skip_cnt_q == 2'h1) begin
                  state_d = bit_invert_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            state_d = bit_invert_pkg::ST_IDLE;
            phase_d = bit_invert_pkg::PH_Q1;
         end
      endcase
   end

   // register the sequencer
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= bit_invert_pkg::ST_IDLE;
         phase_q <= bit_invert_pkg::PH_Q1;
         skip_cnt_q <= 2'h0;
         bit_sel_q <= 3'h0;
         addr_q <= '0;
         data_q <= 8'h00;
      end else begin
         state_q <= state_d;
         phase_q <= phase_d;
         skip_cnt_q <= skip_cnt_d;
         bit_sel_q <= bit_sel_d;
         addr_q <= addr_d;
         data_q <= data_d;
      end
   end

   // --------------------------------------------------
   // memory port and status
   // --------------------------------------------------
   // read in q2, write in q4
   always_comb begin
      mem_rd = (state_q == bit_invert_pkg::ST_EXEC) && (phase_q == bit_invert_pkg::PH_Q2);
      mem_wr = (state_q == bit_invert_pkg::ST_EXEC) && (phase_q == bit_invert_pkg::PH_Q4);
      instr_done = mem_wr;
   end

   // new words only in idle, never against a skip request
   assign instr_ready = (state_q == bit_invert_pkg::ST_IDLE) && !skip_two_word;

   // data outputs straight from the holding registers
   assign mem_addr = addr_q;
   assign mem_wdata = data_q;
   assign status_write_en = 1'b0;

endmodule // bit_invert_instruction

// [testbench/bit_invert_properties.sv]
// checker for the bit-invert executor
`timescale 1ns/1ps
module bit_invert_properties #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // instruction fetch
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic skip_two_word,
   input wire logic extended_set_en,
   // core registers
   input wire logic [3:0] bank_selection_register,
   input wire logic [ADDR_W-1:0] index_base,
   // data memory port
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic mem_rd,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   // status
   input wire logic instr_ready,
   input wire logic instr_done,
   input wire logic status_write_en
);
   logic take;
   logic [15:0] w_q;
   logic [7:0] rd_q;
   logic [3:0] busy_q;
   assign take = instr_ready && instr_valid && instr_word[15:12] == 4'h7 && !skip_two_word;
   // captured word and read byte
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         w_q <= 16'h0000;
         rd_q <= 8'h00;
         busy_q <= 4'h0;
      end else begin
         if (take) w_q <= instr_word;
         if (mem_rd) rd_q <= mem_rdata;
         // busy span mirror: four clocks per instruction, eight per skip
         if (take) busy_q <= 4'h4;
         else if (skip_two_word && busy_q == 4'h0) busy_q <= 4'h8;
         else if (busy_q != 4'h0) busy_q <= busy_q - 4'h1;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   AST_WDATA: assert property (mem_wr |-> mem_wdata == (rd_q ^ (8'h01 << w_q[11:9])))
      else $error("bad write data");
   AST_ACCESS: assert property (mem_rd && !w_q[8]
      && !(extended_set_en && w_q[7:0] <= 8'h5F)
      |-> mem_addr == {(w_q[7:0] >= 8'h60 ? 4'hF : 4'h0), w_q[7:0]})
      else $error("bad access address");
   AST_BANK: assert property (mem_rd && w_q[8]
      |-> mem_addr == {bank_selection_register, w_q[7:0]}) else $error("bad bank address");
   AST_INDEX: assert property (mem_rd && !w_q[8]
      && extended_set_en && w_q[7:0] <= 8'h5F
      |-> mem_addr == index_base + w_q[7:0]) else $error("bad indexed address");
   AST_PHASE: assert property (take |=> !instr_ready ##1 mem_rd ##2 mem_wr && instr_done)
      else $error("bad phase order");
   AST_BUSY: assert property (busy_q != 4'h0 |-> !instr_ready)
      else $error("ready while busy");
   AST_FLAGS: assert property (!status_write_en) else $error("flags written");
   AST_SKIP: assert property (skip_two_word && busy_q == 4'h0
      |=> (!instr_ready) [*8] ##1 (instr_ready || skip_two_word))
      else $error("skip length wrong");
   cover property (take && instr_word[8]);
   cover property (mem_rd && extended_set_en && !w_q[8]);
   cover property (skip_two_word && busy_q == 4'h0);
endmodule // bit_invert_properties

// [testbench/tb_top.sv]
// self-checking bench for the bit-invert executor
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 0, reset_n = 0, instr_valid = 0, skip_two_word = 0, extended_set_en = 0, e;
   logic [15:0] instr_word = 16'h0000, w;
   logic [3:0] bank_selection_register = 4'h0, b4;
   logic [11:0] index_base = 12'h000, mem_addr, ea, ib;
   logic [7:0] mem_rdata = 8'h00, mem_wdata, rd;
   logic mem_rd, mem_wr, instr_ready, instr_done, status_write_en;
   logic [19:0] exp_q[$];
   int n_errors = 0, comparisons = 0, lows = 0;
   bit_invert_instruction bit_invert_instruction_inst (.clk_sys(clk_sys), .reset_n(reset_n),
      .instr_valid(instr_valid), .instr_word(instr_word), .skip_two_word(skip_two_word),
      .extended_set_en(extended_set_en), .bank_selection_register(bank_selection_register),
      .index_base(index_base), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .instr_ready(instr_ready),
      .instr_done(instr_done), .status_write_en(status_write_en));
   task automatic check(logic [19:0] seen, logic [19:0] want);
      comparisons++;
      if (seen !== want) begin
         n_errors++;
         $display("[ERR] %0t got %h want %h", $time, seen, want);
      end
   endtask
   task automatic print_verdict;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial forever #12.5 clk_sys = ~clk_sys;
   initial begin
      #50000 n_errors++;
      print_verdict();
   end
   // each write is checked against the oldest note, mid-cycle where outputs are settled
   always @(negedge clk_sys) begin
      if (mem_wr === 1'b1) begin
         check({19'h00000, instr_done}, 20'h00001);
         check({19'h00000, status_write_en}, 20'h00000);
         if (exp_q.size() == 0) check(20'hFFFFF, 20'h00000);
         else check({mem_addr, mem_wdata},
            exp_q.pop_front());
      end
   end
   // random words, boundary offsets, one foreign opcode, one skip
   initial begin
      void'($urandom(34922));
      repeat (2) @(posedge clk_sys);
      reset_n <= 1;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk_sys);
         w = {4'h7, 12'($urandom)};
         if (i % 3 == 0) w[7:0] = 8'h5F + 8'(i % 2);
         if (i == 5) w[15:12] = 4'h6;
         e = 1'($urandom);
         b4 = 4'($urandom);
         ib = 12'($urandom);
         rd = 8'($urandom);
         ea = w[8] ? {b4, w[7:0]} : (e && w[7:0] <= 8'h5F) ? ib + w[7:0] :
            {(w[7:0] >= 8'h60 ? 4'hF : 4'h0), w[7:0]};
         if (i != 5) exp_q.push_back({ea, rd ^ (8'h01 << w[11:9])});
         instr_word <= w;
         extended_set_en <= e;
         bank_selection_register <= b4;
         index_base <= ib;
         mem_rdata <= rd;
         instr_valid <= 1;
         @(posedge clk_sys);
         instr_valid <= 0;
         repeat (4) @(posedge clk_sys);
      end
      // skip with a matching word offered through it: eight busy clocks, word refused
      skip_two_word <= 1;
      instr_word <= 16'h7000;
      instr_valid <= 1;
      @(posedge clk_sys);
      skip_two_word <= 0;
      for (int k = 0; k < 12; k++) begin
         @(negedge clk_sys);
         if (instr_ready !== 1'b1) lows++;
         @(posedge clk_sys);
         if (k == 6) instr_valid <= 0;
      end
      check(20'(lows), 20'h00008);
      check(20'(exp_q.size()), 20'h00000);
      print_verdict();
   end
endmodule // tb_top
bind bit_invert_instruction bit_invert_properties #(.ADDR_W(ADDR_W)) bit_invert_properties_inst (
   .clk_sys(clk_sys), .reset_n(reset_n), .instr_valid(instr_valid), .instr_word(instr_word),
   .skip_two_word(skip_two_word), .extended_set_en(extended_set_en), .index_base(index_base),
   .bank_selection_register(bank_selection_register), .mem_addr(mem_addr), .mem_rd(mem_rd),
   .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .instr_ready(instr_ready),
   .instr_done(instr_done), .status_write_en(status_write_en));
